// *** common/usb_pwr_irq_pkg.sv ***
`default_nettype none
package usb_pwr_irq_pkg;
  // =========================================================
  // Register offsets (byte offsets on the plain port)
  localparam logic [9:0] OFF_POWER    = 10'h001;
  localparam logic [9:0] OFF_TX_STAT  = 10'h002;
  localparam logic [9:0] OFF_RX_STAT  = 10'h004;
  localparam logic [9:0] OFF_TX_EN    = 10'h006;
  // =========================================================
  // Power register fields
  localparam int BIT_PHY_DOWN    = 0;
  localparam int BIT_SUSPEND     = 1;
  localparam int BIT_RESUME      = 2;
  localparam int BIT_BUS_RESET   = 3;
  localparam int BIT_SOFT_CONN   = 6;
  localparam int BIT_ISO_WAIT    = 7;
  localparam logic [7:0]  POWER_RESET      = 8'h20;
  localparam logic [1:0]  POWER_RSVD_VALUE = 2'h2;
  localparam logic [15:0] TX_EN_RESET      = 16'hFFFF;
  localparam logic [15:0] STAT_RESET       = 16'h0000;
  localparam logic [15:0] RX_RSVD_MASK     = 16'hFFFE;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [9:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {ISO_IDLE, ISO_WAIT_FRAME, ISO_RELEASE} iso_state_t;
endpackage
`default_nettype wire

// *** logic/usb_power_and_ep_interrupts.sv ***
`default_nettype none
module usb_power_and_ep_interrupts (
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic [9:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic        host_mode_i,
  input  wire logic [15:0] tx_ep_configured_i,
  input  wire logic [15:0] rx_ep_configured_i,
  input  wire logic [15:0] tx_ep_event_i,
  input  wire logic [15:0] rx_ep_event_i,
  input  wire logic        bus_reset_seen_i,
  input  wire logic        bus_suspend_seen_i,
  input  wire logic        gen_irq_status_read_i,
  input  wire logic        sof_token_i,
  input  wire logic        in_token_i,
  input  wire logic        tx_packet_ready_i,
  output logic             send_packet_o,
  output logic             send_zero_length_o,
  output logic             transceiver_power_down_o,
  output logic             line_drive_enable_o,
  output logic             resume_signal_o,
  output logic             host_reset_signal_o,
  output logic             suspend_mode_o,
  output logic             usb_irq_o
);
  // =========================================================
  // Register access decode
  usb_pwr_irq_pkg::reg_req_t req;
  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};

  logic wr_power;
  logic rd_power;
  logic rd_tx;
  logic rd_rx;
  logic wr_tx_en;
  assign wr_power = req.wr && (req.addr == usb_pwr_irq_pkg::OFF_POWER);
  assign rd_power = req.rd && (req.addr == usb_pwr_irq_pkg::OFF_POWER);
  assign rd_tx    = req.rd && (req.addr == usb_pwr_irq_pkg::OFF_TX_STAT);
  assign rd_rx    = req.rd && (req.addr == usb_pwr_irq_pkg::OFF_RX_STAT);
  assign wr_tx_en = req.wr && (req.addr == usb_pwr_irq_pkg::OFF_TX_EN);

  // =========================================================
  // Power and signalling control
  logic iso_wait_for_frame;
  logic soft_line_connect;
  logic resume_bit;
  logic suspend_flag;
  logic phy_down;
  logic host_reset_bit;
  logic bus_reset_sync1;
  logic bus_reset_sync2;
  logic suspend_sync1;
  logic suspend_sync2;
  logic [15:0] wd;
  assign wd = req.wdata;

  // Bus line state comes from the transceiver domain
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_reset_sync1 <= 1'b0;
      bus_reset_sync2 <= 1'b0;
    end else begin
      bus_reset_sync1 <= bus_reset_seen_i;
      bus_reset_sync2 <= bus_reset_sync1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      suspend_sync1 <= 1'b0;
      suspend_sync2 <= 1'b0;
    end else begin
      suspend_sync1 <= bus_suspend_seen_i;
      suspend_sync2 <= suspend_sync1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phy_down <= 1'b0;
    end else if (wr_power && wd[usb_pwr_irq_pkg::BIT_PHY_DOWN]) begin
      phy_down <= 1'b1;
    end
  end

  // Device-only fields keep their value across host-mode writes
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      iso_wait_for_frame <= 1'b0;
    end else if (wr_power && !host_mode_i) begin
      iso_wait_for_frame <= wd[usb_pwr_irq_pkg::BIT_ISO_WAIT];
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      soft_line_connect <= 1'b0;
    end else if (wr_power && !host_mode_i) begin
      soft_line_connect <= wd[usb_pwr_irq_pkg::BIT_SOFT_CONN];
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      resume_bit <= 1'b0;
    end else if (wr_power) begin
      resume_bit <= wd[usb_pwr_irq_pkg::BIT_RESUME];
    end
  end

  // Host-only bus reset drive
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_reset_bit <= 1'b0;
    end else if (wr_power && host_mode_i) begin
      host_reset_bit <= wd[usb_pwr_irq_pkg::BIT_BUS_RESET];
    end
  end

  // Set wins over clear: a suspend seen during the clearing read stays
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      suspend_flag <= 1'b0;
    end else if (host_mode_i) begin
      if (wr_power && wd[usb_pwr_irq_pkg::BIT_SUSPEND]) begin
        suspend_flag <= 1'b1;
      end else if (wr_power && wd[usb_pwr_irq_pkg::BIT_RESUME]) begin
        suspend_flag <= 1'b0;
      end
    end else if (suspend_sync2) begin
      suspend_flag <= 1'b1;
    end else if (gen_irq_status_read_i ||
                 (wr_power && wd[usb_pwr_irq_pkg::BIT_RESUME])) begin
      suspend_flag <= 1'b0;
    end
  end

  // The resume write also clears the suspend flag, so sample it on the write
  logic resume_start;
  assign resume_start = wr_power && wd[usb_pwr_irq_pkg::BIT_RESUME] && suspend_flag;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      resume_signal_o <= 1'b0;
    end else begin
      resume_signal_o <= resume_start || (resume_bit && resume_signal_o);
    end
  end

  // =========================================================
  // Line state outputs
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      transceiver_power_down_o <= 1'b0;
    end else begin
      transceiver_power_down_o <= phy_down;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_drive_enable_o <= 1'b0;
    end else begin
      line_drive_enable_o <= host_mode_i || soft_line_connect;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_reset_signal_o <= 1'b0;
    end else begin
      host_reset_signal_o <= host_mode_i && host_reset_bit;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      suspend_mode_o <= 1'b0;
    end else begin
      suspend_mode_o <= suspend_flag;
    end
  end

  // =========================================================
  // Isochronous frame hold
  usb_pwr_irq_pkg::iso_state_t iso_state;
  usb_pwr_irq_pkg::iso_state_t next_iso_state;
  logic iso_active;
  assign iso_active = iso_wait_for_frame && !host_mode_i;

  always_comb begin
    next_iso_state = iso_state;
    case (iso_state)
      usb_pwr_irq_pkg::ISO_IDLE: begin
        if (tx_packet_ready_i && iso_active) begin
          next_iso_state = usb_pwr_irq_pkg::ISO_WAIT_FRAME;
        end
      end
      usb_pwr_irq_pkg::ISO_WAIT_FRAME: begin
        // Leaving iso mode frees a held packet
        if (sof_token_i) begin
          next_iso_state = usb_pwr_irq_pkg::ISO_RELEASE;
        end else if (!iso_active) begin
          next_iso_state = usb_pwr_irq_pkg::ISO_IDLE;
        end
      end
      usb_pwr_irq_pkg::ISO_RELEASE: begin
        if (in_token_i || !tx_packet_ready_i) begin
          next_iso_state = usb_pwr_irq_pkg::ISO_IDLE;
        end
      end
      default: next_iso_state = usb_pwr_irq_pkg::ISO_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      iso_state <= usb_pwr_irq_pkg::ISO_IDLE;
    end else begin
      iso_state <= next_iso_state;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      send_packet_o      <= 1'b0;
      send_zero_length_o <= 1'b0;
    end else begin
      send_packet_o      <= 1'b0;
      send_zero_length_o <= 1'b0;
      if (in_token_i) begin
        if (!iso_active || iso_state == usb_pwr_irq_pkg::ISO_RELEASE) begin
          send_packet_o <= tx_packet_ready_i;
        end else begin
          send_zero_length_o <= 1'b1;
        end
      end
    end
  end

  // =========================================================
  // Endpoint interrupt status and enable
  logic [15:0] tx_status;
  logic [15:0] rx_status;
  logic [15:0] tx_enable;
  logic [15:0] tx_set;
  logic [15:0] rx_set;
  // Bit 0 events carry both control directions
  assign tx_set = tx_ep_event_i & tx_ep_configured_i;
  assign rx_set = rx_ep_event_i & rx_ep_configured_i & usb_pwr_irq_pkg::RX_RSVD_MASK;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_status <= usb_pwr_irq_pkg::STAT_RESET;
    end else begin
      tx_status <= (rd_tx ? 16'h0000 : tx_status) | tx_set;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_status <= usb_pwr_irq_pkg::STAT_RESET;
    end else begin
      rx_status <= (rd_rx ? 16'h0000 : rx_status) | rx_set;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_enable <= usb_pwr_irq_pkg::TX_EN_RESET;
    end else if (wr_tx_en) begin
      tx_enable <= wd;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      usb_irq_o <= 1'b0;
    end else begin
      usb_irq_o <= |(tx_status & tx_ep_configured_i & tx_enable);
    end
  end

  // =========================================================
  // Read data, one cycle after the strobe
  logic [7:0] power_view;
  always_comb begin
    power_view = 8'h00;
    power_view[usb_pwr_irq_pkg::BIT_PHY_DOWN] = phy_down;
    power_view[usb_pwr_irq_pkg::BIT_SUSPEND]  = suspend_flag;
    power_view[usb_pwr_irq_pkg::BIT_RESUME]   = resume_bit;
    if (host_mode_i) begin
      power_view[7:4] = {2'h0, usb_pwr_irq_pkg::POWER_RSVD_VALUE};
      power_view[usb_pwr_irq_pkg::BIT_BUS_RESET] = host_reset_bit;
    end else begin
      power_view[usb_pwr_irq_pkg::BIT_ISO_WAIT]  = iso_wait_for_frame;
      power_view[usb_pwr_irq_pkg::BIT_SOFT_CONN] = soft_line_connect;
      power_view[5:4] = usb_pwr_irq_pkg::POWER_RSVD_VALUE;
      power_view[usb_pwr_irq_pkg::BIT_BUS_RESET] = bus_reset_sync2;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (rd_power) begin
      reg_rdata_o <= {8'h00, power_view};
    end else if (rd_tx) begin
      reg_rdata_o <= tx_status & tx_ep_configured_i;
    end else if (rd_rx) begin
      reg_rdata_o <= rx_status & rx_ep_configured_i & usb_pwr_irq_pkg::RX_RSVD_MASK;
    end else if (req.rd && req.addr == usb_pwr_irq_pkg::OFF_TX_EN) begin
      reg_rdata_o <= tx_enable;
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// *** sim/tb_usb_power_and_ep_interrupts.sv ***
`default_nettype none
module tb_usb_power_and_ep_interrupts;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    bit          wr;
    logic [9:0]  addr;
    logic [15:0] data;
  } row_t;
  logic        clk_sys_i, arst_n_i, reg_wr_i, reg_rd_i, host_mode_i, in_token_i;
  logic        gen_irq_status_read_i, tx_packet_ready_i, sof_token_i, resume_signal_o;
  logic        bus_reset_seen_i, bus_suspend_seen_i, send_packet_o, send_zero_length_o;
  logic        transceiver_power_down_o, line_drive_enable_o, host_reset_signal_o;
  logic        suspend_mode_o, usb_irq_o;
  logic [9:0]  reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, tx_ep_configured_i, rx_ep_configured_i;
  logic [15:0] tx_ep_event_i, rx_ep_event_i;
  int          failures, checks_done;
  row_t rows [7] = '{
    '{0, usb_pwr_irq_pkg::OFF_POWER, 16'h0020},
    '{0, usb_pwr_irq_pkg::OFF_TX_EN, 16'hFFFF},
    '{0, usb_pwr_irq_pkg::OFF_TX_STAT, 16'h0000},
    '{0, usb_pwr_irq_pkg::OFF_RX_STAT, 16'h0000},
    '{0, 10'h010, 16'h0000},
    '{1, usb_pwr_irq_pkg::OFF_POWER, 16'h00C0},
    '{0, usb_pwr_irq_pkg::OFF_POWER, 16'h00E0}};
  usb_host_model i_host (
    .clk_sys_i     (clk_sys_i),
    .sof_o         (sof_token_i),
    .in_o          (in_token_i),
    .bus_reset_o   (bus_reset_seen_i),
    .bus_suspend_o (bus_suspend_seen_i)
  );
  usb_power_and_ep_interrupts i_dut (
    .clk_sys_i                (clk_sys_i),
    .arst_n_i                 (arst_n_i),
    .reg_addr_i               (reg_addr_i),
    .reg_wdata_i              (reg_wdata_i),
    .reg_wr_i                 (reg_wr_i),
    .reg_rd_i                 (reg_rd_i),
    .reg_rdata_o              (reg_rdata_o),
    .host_mode_i              (host_mode_i),
    .tx_ep_configured_i       (tx_ep_configured_i),
    .rx_ep_configured_i       (rx_ep_configured_i),
    .tx_ep_event_i            (tx_ep_event_i),
    .rx_ep_event_i            (rx_ep_event_i),
    .bus_reset_seen_i         (bus_reset_seen_i),
    .bus_suspend_seen_i       (bus_suspend_seen_i),
    .gen_irq_status_read_i    (gen_irq_status_read_i),
    .sof_token_i              (sof_token_i),
    .in_token_i               (in_token_i),
    .tx_packet_ready_i        (tx_packet_ready_i),
    .send_packet_o            (send_packet_o),
    .send_zero_length_o       (send_zero_length_o),
    .transceiver_power_down_o (transceiver_power_down_o),
    .line_drive_enable_o      (line_drive_enable_o),
    .resume_signal_o          (resume_signal_o),
    .host_reset_signal_o      (host_reset_signal_o),
    .suspend_mode_o           (suspend_mode_o),
    .usb_irq_o                (usb_irq_o)
  );
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] exp);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'h0;
    #1 chk(reg_rdata_o, exp);
  endtask
  task automatic ev(input logic [15:0] tx, input logic [15:0] rx);
    @(posedge clk_sys_i);
    tx_ep_event_i <= tx;
    rx_ep_event_i <= rx;
    @(posedge clk_sys_i);
    tx_ep_event_i <= 16'h0000;
    rx_ep_event_i <= 16'h0000;
  endtask
  // ==========
  // Clock, watchdog, sequence
  initial begin
    clk_sys_i = 1'h0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #100000;
    failures++;
    complete_run();
  end
  initial begin
    {arst_n_i, reg_wr_i, reg_rd_i, host_mode_i, gen_irq_status_read_i} = 5'h00;
    {reg_addr_i, tx_packet_ready_i} = 11'h000;
    {reg_wdata_i, tx_ep_event_i, rx_ep_event_i} = 48'h0;
    tx_ep_configured_i = 16'h00FF;
    rx_ep_configured_i = 16'hFFFF;
    repeat (20) @(posedge clk_sys_i);
    arst_n_i <= 1'h1;
    foreach (rows[i])
      if (rows[i].wr) wr(rows[i].addr, rows[i].data);
      else rd(rows[i].addr, rows[i].data);
    chk(16'(line_drive_enable_o), 16'h0001);
    tx_packet_ready_i <= 1'h1;
    i_host.token(0, 2);
    #1 chk(16'({send_packet_o, send_zero_length_o}), 16'h0001);
    i_host.token(1, 1);
    i_host.token(0, 2);
    #1 chk(16'({send_packet_o, send_zero_length_o}), 16'h0002);
    tx_packet_ready_i <= 1'h0;
    ev(16'hFF01, 16'h0000);
    step(2);
    chk(16'(usb_irq_o), 16'h0001);
    rd(usb_pwr_irq_pkg::OFF_TX_STAT, 16'h0001);
    rd(usb_pwr_irq_pkg::OFF_TX_STAT, 16'h0000);
    chk(16'(usb_irq_o), 16'h0000);
    wr(usb_pwr_irq_pkg::OFF_TX_EN, 16'h0000);
    ev(16'h0002, 16'h0000);
    step(2);
    chk(16'(usb_irq_o), 16'h0000);
    rd(usb_pwr_irq_pkg::OFF_TX_STAT, 16'h0002);
    wr(usb_pwr_irq_pkg::OFF_TX_EN, 16'hFFFF);
    i_host.line(0, 1);
    step(4);
    chk(16'(suspend_mode_o), 16'h0001);
    i_host.line(0, 0);
    step(3);
    wr(usb_pwr_irq_pkg::OFF_POWER, 16'h00C4);
    step(2);
    chk(16'({resume_signal_o, suspend_mode_o}), 16'h0002);
    wr(usb_pwr_irq_pkg::OFF_POWER, 16'h00C0);
    step(2);
    chk(16'(resume_signal_o), 16'h0000);
    i_host.line(0, 1);
    step(4);
    i_host.line(0, 0);
    step(3);
    chk(16'(suspend_mode_o), 16'h0001);
    gen_irq_status_read_i <= 1'h1;
    step(1);
    gen_irq_status_read_i <= 1'h0;
    step(2);
    chk(16'(suspend_mode_o), 16'h0000);
    i_host.line(1, 0);
    step(4);
    rd(usb_pwr_irq_pkg::OFF_POWER, 16'h00E8);
    i_host.line(0, 0);
    step(4);
    rd(usb_pwr_irq_pkg::OFF_POWER, 16'h00E0);
    wr(usb_pwr_irq_pkg::OFF_POWER, 16'h00C1);
    wr(usb_pwr_irq_pkg::OFF_POWER, 16'h00C0);
    step(2);
    chk(16'(transceiver_power_down_o), 16'h0001);
    ev(16'h0000, 16'h0003);
    rd(usb_pwr_irq_pkg::OFF_RX_STAT, 16'h0002);
    rd(usb_pwr_irq_pkg::OFF_RX_STAT, 16'h0000);
    host_mode_i <= 1'h1;
    wr(usb_pwr_irq_pkg::OFF_POWER, 16'h0002);
    wr(usb_pwr_irq_pkg::OFF_POWER, 16'h0000);
    step(2);
    chk(16'({suspend_mode_o, line_drive_enable_o}), 16'h0003);
    wr(usb_pwr_irq_pkg::OFF_POWER, 16'h0008);
    step(2);
    chk(16'(host_reset_signal_o), 16'h0001);
    wr(usb_pwr_irq_pkg::OFF_POWER, 16'h0000);
    step(2);
    chk(16'(host_reset_signal_o), 16'h0000);
    host_mode_i <= 1'h0;
    step(1);
    arst_n_i <= 1'h0;
    step(2);
    arst_n_i <= 1'h1;
    chk(16'(transceiver_power_down_o), 16'h0000);
    rd(usb_pwr_irq_pkg::OFF_POWER, 16'h0020);
    complete_run();
  end
endmodule
bind usb_power_and_ep_interrupts usb_pwr_irq_sva i_sva (.*);
`default_nettype wire

// *** sim/usb_host_model.sv ***
`default_nettype none
module usb_host_model (
  input  wire logic clk_sys_i,
  output var logic  sof_o,
  output var logic  in_o,
  output var logic  bus_reset_o,
  output var logic  bus_suspend_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sof_o = 1'h0;
    in_o = 1'h0;
    bus_reset_o = 1'h0;
    bus_suspend_o = 1'h0;
  end
  // Gap lets the host be prompt or slow between tokens
  task automatic token(input bit sof, input int gap);
    repeat (gap) @(posedge clk_sys_i);
    if (sof) sof_o <= 1'h1;
    else in_o <= 1'h1;
    @(posedge clk_sys_i);
    sof_o <= 1'h0;
    in_o <= 1'h0;
  endtask
  task automatic line(input bit rst, input bit susp);
    @(posedge clk_sys_i);
    bus_reset_o <= rst;
    bus_suspend_o <= susp;
  endtask
endmodule
`default_nettype wire

// *** sim/usb_pwr_irq_sva.sv ***
`default_nettype none
module usb_pwr_irq_sva (
  input wire logic        clk_sys_i,
  input wire logic        arst_n_i,
  input wire logic [9:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        host_mode_i,
  input wire logic [15:0] tx_ep_configured_i,
  input wire logic [15:0] tx_ep_event_i,
  input wire logic        in_token_i,
  input wire logic        send_packet_o,
  input wire logic        send_zero_length_o,
  input wire logic        transceiver_power_down_o,
  input wire logic        line_drive_enable_o,
  input wire logic        usb_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tx_rd;
  logic pw_wr;
  logic no_ev;
  assign tx_rd = reg_rd_i && reg_addr_i == usb_pwr_irq_pkg::OFF_TX_STAT;
  assign pw_wr = reg_wr_i && reg_addr_i == usb_pwr_irq_pkg::OFF_POWER;
  assign no_ev = tx_ep_event_i == 16'h0000;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // ==========
  // Checks
  a_rdata_idle: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000) else $error("data outside read slot");
  a_phy_set: assert property (
    pw_wr && reg_wdata_i[0] |-> ##2 transceiver_power_down_o) else $error("phy not down");
  a_phy_sticky: assert property (
    transceiver_power_down_o |=> transceiver_power_down_o) else $error("phy woke up");
  a_read_clear: assert property (
    (tx_rd && no_ev) ##1 no_ev ##1 (tx_rd && no_ev) |=> reg_rdata_o == 16'h0000)
    else $error("status not cleared");
  a_unconf_zero: assert property (
    tx_rd |=> (reg_rdata_o & ~$past(tx_ep_configured_i)) == 16'h0000)
    else $error("unconfigured flag seen");
  a_send_cause: assert property (
    send_packet_o || send_zero_length_o |-> $past(in_token_i)
    && !(send_packet_o && send_zero_length_o)) else $error("bad send pulse");
  a_host_drive: assert property (
    host_mode_i [*2] |=> line_drive_enable_o) else $error("host lines undriven");
  a_mask_irq: assert property (
    reg_wr_i && reg_addr_i == usb_pwr_irq_pkg::OFF_TX_EN && reg_wdata_i == 16'h0000
    ##1 !reg_wr_i |=> !usb_irq_o) else $error("masked irq raised");
endmodule
`default_nettype wire
